// [logic/llcr_pkg.sv]
/*
 * shared constants and carrier types for the lane link configuration
 * readback bank.
 * assumes a 32-bit axi4-lite register bus with one register per word.
 */
`default_nettype none

package llcr_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int          ADDR_W     = 12;
    localparam int          IDX_W      = 10;
    localparam int          WORD_SHIFT = 2;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam int               LANE_COUNT    = 4;
    localparam logic [IDX_W-1:0] LANE_BASE_IDX = 10'h120;
    localparam int               LANE_STRIDE   = 16;
    localparam int               LANE_SHIFT    = 4;
    localparam logic [3:0]       CFG_BYTES     = 4'he;
    localparam logic [IDX_W-1:0] PAIR_LOW_IDX    [2] = '{10'h12e, 10'h14e};
    localparam logic [IDX_W-1:0] PAIR_HIGH_IDX   [2] = '{10'h12f, 10'h14f};
    localparam logic [IDX_W-1:0] PAIR_CHOICE_IDX [2] = '{10'h13e, 10'h15e};

    // ****************************************************************
    // per-lane configuration byte numbers
    // ****************************************************************
    localparam logic [3:0] CFG_LINK_IDENT     = 4'h0;
    localparam logic [3:0] CFG_ADJCOUNT_BANK  = 4'h1;
    localparam logic [3:0] CFG_ADJUST_LANEID  = 4'h2;
    localparam logic [3:0] CFG_SCRAMBLE_LANES = 4'h3;
    localparam logic [3:0] CFG_OCTETS_FRAME   = 4'h4;
    localparam logic [3:0] CFG_FRAMES_MULTI   = 4'h5;
    localparam logic [3:0] CFG_CONVERTERS     = 4'h6;
    localparam logic [3:0] CFG_CTRLBITS_RESOL = 4'h7;
    localparam logic [3:0] CFG_SUBCLASS_WIDTH = 4'h8;
    localparam logic [3:0] CFG_VERSION_SAMPLES = 4'h9;
    localparam logic [3:0] CFG_DENSITY_CTRLW  = 4'ha;
    localparam logic [3:0] CFG_SPARE_ONE      = 4'hb;
    localparam logic [3:0] CFG_SPARE_TWO      = 4'hc;
    localparam logic [3:0] CFG_CHECKSUM       = 4'hd;

    // ****************************************************************
    // field codes and reset values
    // ****************************************************************
    localparam logic [2:0] SUBCLASS_0     = 3'h0;
    localparam logic [2:0] SUBCLASS_1     = 3'h1;
    localparam logic [2:0] SUBCLASS_2     = 3'h2;
    localparam logic [2:0] VERSION_ORIG   = 3'h0;
    localparam logic [2:0] VERSION_B      = 3'h1;
    localparam logic [7:0] CHOICE_RESET   = 8'h00;
    localparam int         CHOICE_BIT     = 0;
    localparam int         WORD_W         = 16;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0] rx_link_ident;
        logic [3:0] rx_adjust_count;
        logic [3:0] rx_bank_ident;
        logic       rx_adjust_direction;
        logic       rx_phase_adjust_req;
        logic [4:0] rx_lane_ident;
        logic       rx_scramble_on;
        logic [4:0] rx_lane_count_m1;
        logic [7:0] rx_octets_per_frame_m1;
        logic [4:0] rx_frames_per_multi_m1;
        logic [7:0] rx_converters_m1;
        logic [1:0] rx_control_bit_count;
        logic [4:0] rx_resolution_m1;
        logic [2:0] rx_subclass_code;
        logic [4:0] rx_bits_per_sample_m1;
        logic [2:0] rx_standard_version;
        logic [4:0] rx_samples_per_frame_m1;
        logic       rx_high_density;
        logic [4:0] rx_ctrl_words_per_frame;
        logic [7:0] rx_spare_octet_one;
        logic [7:0] rx_spare_octet_two;
        logic [7:0] rx_config_checksum;
    } llcr_lane_cfg_type;

    typedef struct packed {
        logic       ok;
        logic [7:0] data;
    } llcr_rd_type;

endpackage

`default_nettype wire

// [logic/llcr_top.sv]
/*
 * lane link configuration readback bank: per-lane alignment parameters
 * and a captured data-path word per lane pair, behind axi4-lite.
 * assumes the alignment decoder pulses cfg_load with the decoded fields,
 * and that the data-path strobe and lane words share aclk.
 */
// Decided for this implementation: the AXI4-Lite slave port.
// Operation
// - lane byte 0 is link identifier
// - byte 1 adjust count high, bank low
// - byte 2 direction, phase request, lane id
// - byte 3 scrambling bit 7, lanes
// - byte 4 octets per frame minus one
// - byte 5 frames per multiframe, upper zero
// - byte 6 converters minus one
// - byte 7 control bits, resolution
// - byte 8 subclass code in bits 7:5
// - byte 8 bits per sample low bits
// - byte 9 standard version bits 7:5
// - byte 9 samples per frame low bits
// - byte 10 high density, control words
// - bytes 11-13 spare octets and checksum
// - strobe latches both pair words, pair 1/0 and pair 3/2
// - samples read zero until strobe; choice resets
// - values come from decoded alignment sequence
`timescale 1ns/1ps
`default_nettype none

module llcr_top
    import llcr_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic                          awvalid,
    output var  logic                          awready,
    input  wire logic [ADDR_W-1:0]             awaddr,
    input  wire logic [2:0]                    awprot,
    // axi4-lite write data
    input  wire logic                          wvalid,
    output var  logic                          wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    // axi4-lite write response
    output var  logic                          bvalid,
    input  wire logic                          bready,
    output var  logic [1:0]                    bresp,
    // axi4-lite read address
    input  wire logic                          arvalid,
    output var  logic                          arready,
    input  wire logic [ADDR_W-1:0]             araddr,
    input  wire logic [2:0]                    arprot,
    // axi4-lite read data
    output var  logic                          rvalid,
    input  wire logic                          rready,
    output var  logic [31:0]                   rdata,
    output var  logic [1:0]                    rresp,
    // decoded alignment configuration
    input  wire llcr_lane_cfg_type             cfg_in [LANES],
    input  wire logic [LANES-1:0]              cfg_load,
    // lane data path
    input  wire logic [LANES-1:0][WORD_W-1:0]  lane_datapath,
    input  wire logic                          datapath_capture_strobe
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the map has room for exactly four lanes in two pairs
    if (LANES != LANE_COUNT) begin : g_bad_lanes
        $error("llcr_top: LANES must be four");
    end

    localparam int PAIRS = LANES / 2;

    // ****************************************************************
    // state
    // ****************************************************************
    llcr_lane_cfg_type       cfg_q [LANES];
    logic [WORD_W-1:0]       pair_word [PAIRS];
    logic [7:0]              pair_choice [PAIRS];
    logic                    aw_got;
    logic                    w_got;
    logic [IDX_W-1:0]        wr_idx;
    logic [7:0]              wr_byte;
    logic                    wr_lane0;
    logic                    do_write;
    llcr_rd_type             next_rd;

    // ****************************************************************
    // decoding
    // ****************************************************************
    function automatic logic [IDX_W-1:0] word_index(
        input logic [ADDR_W-1:0] addr
    );
        word_index = addr[WORD_SHIFT +: IDX_W];
    endfunction

    function automatic logic is_choice(input logic [IDX_W-1:0] idx);
        is_choice = 1'b0;
        for (int p = 0; p < PAIRS; p++) begin
            if (idx == PAIR_CHOICE_IDX[p]) begin
                is_choice = 1'b1;
            end
        end
    endfunction

    function automatic logic [7:0] cfg_byte(
        input llcr_lane_cfg_type c,
        input logic [3:0]        b
    );
        case (b)
            CFG_LINK_IDENT:     cfg_byte = c.rx_link_ident;
            CFG_ADJCOUNT_BANK:  cfg_byte = {c.rx_adjust_count,
                                            c.rx_bank_ident};
            CFG_ADJUST_LANEID:  cfg_byte = {1'b0, c.rx_adjust_direction,
                                            c.rx_phase_adjust_req,
                                            c.rx_lane_ident};
            CFG_SCRAMBLE_LANES: cfg_byte = {c.rx_scramble_on, 2'b00,
                                            c.rx_lane_count_m1};
            CFG_OCTETS_FRAME:   cfg_byte = c.rx_octets_per_frame_m1;
            CFG_FRAMES_MULTI:   cfg_byte = {3'b000,
                                    c.rx_frames_per_multi_m1};
            CFG_CONVERTERS:     cfg_byte = c.rx_converters_m1;
            CFG_CTRLBITS_RESOL: cfg_byte = {c.rx_control_bit_count, 1'b0,
                                            c.rx_resolution_m1};
            CFG_SUBCLASS_WIDTH: cfg_byte = {c.rx_subclass_code,
                                    c.rx_bits_per_sample_m1};
            CFG_VERSION_SAMPLES: cfg_byte = {c.rx_standard_version,
                                    c.rx_samples_per_frame_m1};
            CFG_DENSITY_CTRLW:  cfg_byte = {c.rx_high_density, 2'b00,
                                    c.rx_ctrl_words_per_frame};
            CFG_SPARE_ONE:      cfg_byte = c.rx_spare_octet_one;
            CFG_SPARE_TWO:      cfg_byte = c.rx_spare_octet_two;
            CFG_CHECKSUM:       cfg_byte = c.rx_config_checksum;
            default:            cfg_byte = 8'h00;
        endcase
    endfunction

    // pair word registers are checked last so they win over the lane blocks' tails
    function automatic llcr_rd_type read_reg(input logic [IDX_W-1:0] idx);
        llcr_rd_type      r;
        logic [IDX_W-1:0] rel;
        r   = '{ok: 1'b0, data: 8'h00};
        rel = idx - LANE_BASE_IDX;
        if (is_choice(idx)) begin
            // write-only: reads back as zero
            r.ok = 1'b1;
        end else if (idx >= LANE_BASE_IDX
                     && rel < IDX_W'(LANES * LANE_STRIDE)
                     && 4'(rel) < CFG_BYTES) begin
            r.ok   = 1'b1;
            r.data = cfg_byte(cfg_q[2'(rel >> LANE_SHIFT)], 4'(rel));
        end
        for (int p = 0; p < PAIRS; p++) begin
            if (idx == PAIR_LOW_IDX[p]) begin
                r.ok   = 1'b1;
                r.data = pair_word[p][7:0];
            end
            if (idx == PAIR_HIGH_IDX[p]) begin
                r.ok   = 1'b1;
                r.data = pair_word[p][WORD_W-1:8];
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // alignment configuration capture
    // ****************************************************************
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_q[l] <= '0;
            end else if (cfg_load[l]) begin
                cfg_q[l] <= cfg_in[l];
            end
        end
    end

    // ****************************************************************
    // data-path capture per lane pair
    // ****************************************************************
    assign do_write = aw_got && w_got && !bvalid;

    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        // software writes 0 for lower lane, 1 for upper lane
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pair_choice[p] <= CHOICE_RESET;
            end else if (do_write && wr_lane0
                         && wr_idx == PAIR_CHOICE_IDX[p]) begin
                pair_choice[p] <= wr_byte;
            end
        end

        // held between strobes so low and high reads agree
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pair_word[p] <= '0;
            end else if (datapath_capture_strobe) begin
                pair_word[p] <= pair_choice[p][CHOICE_BIT]
                              ? lane_datapath[2*p+1]
                              : lane_datapath[2*p];
            end
        end
    end

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    // address and data may arrive in either order; both wait for the other
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_got  <= 1'b0;
            wr_idx  <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            wr_idx  <= word_index(awaddr);
        end else if (do_write) begin
            aw_got  <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready   <= 1'b1;
            w_got    <= 1'b0;
            wr_byte  <= 8'h00;
            wr_lane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wready   <= 1'b0;
            w_got    <= 1'b1;
            wr_byte  <= wdata[7:0];
            wr_lane0 <= wstrb[0];
        end else if (do_write) begin
            w_got    <= 1'b0;
        end else if (bvalid && bready) begin
            wready   <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= is_choice(wr_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    assign next_rd = read_reg(word_index(araddr));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, next_rd.data};
            rresp   <= next_rd.ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ar_take;
    logic [IDX_W-1:0] ar_idx;
    assign ar_take = arvalid && arready;
    assign ar_idx  = word_index(araddr);

    property p_link_ident;
        ar_take && ar_idx == LANE_BASE_IDX + IDX_W'(CFG_LINK_IDENT)
        |=> rvalid && rdata[7:0] == $past(cfg_q[0].rx_link_ident);
    endproperty
    a_link_ident: assert property (p_link_ident)
        else $error("lane 0 identifier read mismatch");

    property p_adjust_byte;
        ar_take && ar_idx == LANE_BASE_IDX + IDX_W'(LANE_STRIDE)
                             + IDX_W'(CFG_ADJUST_LANEID)
        |=> !rdata[7] && rdata[6] == $past(cfg_q[1].rx_adjust_direction)
            && rdata[4:0] == $past(cfg_q[1].rx_lane_ident);
    endproperty
    a_adjust_byte: assert property (p_adjust_byte)
        else $error("lane 1 adjust byte layout wrong");

    property p_frames_upper;
        ar_take && ar_idx == LANE_BASE_IDX + IDX_W'(CFG_FRAMES_MULTI)
        |=> rdata[7:5] == 3'h0 && rresp == RESP_OKAY;
    endproperty
    a_frames_upper: assert property (p_frames_upper)
        else $error("frames byte upper bits not zero");

    property p_subclass;
        ar_take && ar_idx == LANE_BASE_IDX + IDX_W'(CFG_SUBCLASS_WIDTH)
        |=> rdata[7:5] == $past(cfg_q[0].rx_subclass_code)
            && rdata[4:0] == $past(cfg_q[0].rx_bits_per_sample_m1);
    endproperty
    a_subclass: assert property (p_subclass)
        else $error("subclass byte mismatch");

    property p_cfg_load;
        cfg_load[2] |=> cfg_q[2] == $past(cfg_in[2]);
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("decoded configuration not latched");

    property p_capture_upper;
        datapath_capture_strobe && pair_choice[0][CHOICE_BIT]
        |=> pair_word[0] == $past(lane_datapath[1]);
    endproperty
    a_capture_upper: assert property (p_capture_upper)
        else $error("pair 1/0 did not capture lane 1");

    // reference copy of the last lane 0 word, kept apart from the capture
    // path so a read long after the strobe is still checked
    logic [WORD_W-1:0] chk_lane0_word;
    logic              chk_lane0_live;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_lane0_live <= 1'b0;
            chk_lane0_word <= '0;
        end else if (datapath_capture_strobe) begin
            chk_lane0_live <= !pair_choice[0][CHOICE_BIT];
            chk_lane0_word <= lane_datapath[0];
        end
    end

    property p_capture_read;
        chk_lane0_live && ar_take && ar_idx == PAIR_HIGH_IDX[0]
        |=> rdata[7:0] == $past(chk_lane0_word[WORD_W-1:8]);
    endproperty
    a_capture_read: assert property (p_capture_read)
        else $error("pair 1/0 high byte read mismatch");

    property p_hold;
        !datapath_capture_strobe |=> $stable(pair_word[1]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("captured word changed without strobe");

    property p_choice_reset;
        $rose(aresetn) |-> pair_choice[1] == CHOICE_RESET;
    endproperty
    a_choice_reset: assert property (p_choice_reset)
        else $error("pair 3/2 choice not reset");

    property p_write_resp;
        aw_got && w_got && !bvalid |=> bvalid ##0 !aw_got && !w_got;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing");

    c_read_cfg:  cover property (ar_take && ar_idx == LANE_BASE_IDX);
    c_choice_wr: cover property (do_write && is_choice(wr_idx));
    c_capture:   cover property (datapath_capture_strobe
                                 && pair_choice[1][CHOICE_BIT]);
    c_bad_read:  cover property (rvalid && rresp == RESP_SLVERR);

endmodule

`default_nettype wire

// [sim/llcr_far_model.sv]
/* far-side model: alignment decoder outputs and live lane data words.
   assumes the bench holds cfg_next steady while a load is pending. */
`timescale 1ns/1ps
`default_nettype none
module llcr_far_model
    import llcr_pkg::*;
(
    // clock and reset
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    // bench requests
    input  wire llcr_lane_cfg_type                 cfg_next [LANE_COUNT],
    input  wire logic [LANE_COUNT-1:0]             load_req,
    input  wire logic                              strobe_req,
    // towards the block
    output var  llcr_lane_cfg_type                 cfg_in [LANE_COUNT],
    output var  logic [LANE_COUNT-1:0]             cfg_load,
    output var  logic [LANE_COUNT-1:0][WORD_W-1:0] lane_datapath,
    output var  logic                              datapath_capture_strobe
);
    logic [11:0] tick;
    always_ff @(posedge aclk) begin
        tick <= aresetn ? tick + 12'h001 : 12'h000;
    end
    always_ff @(posedge aclk) begin
        cfg_load <= aresetn ? load_req : 4'h0;
        datapath_capture_strobe <= aresetn & strobe_req;
    end
    // fields are stale outside a load, so show their inverse
    always_comb begin
        for (int l = 0; l < LANE_COUNT; l++) begin
            cfg_in[l] = cfg_load[l] ? cfg_next[l]
                                    : llcr_lane_cfg_type'(~cfg_next[l]);
            lane_datapath[l] = {tick, 4'(l)};
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
/* self-checking bench for the lane configuration readback bank.
   assumes the far-side model feeds the lane and alignment inputs. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import llcr_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic strobe_req, datapath_capture_strobe;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, load_req, cfg_load;
    logic [1:0] bresp, rresp, resp, sel;
    logic [127:0] raw;
    llcr_lane_cfg_type rnd_cfg, cfg_next [LANE_COUNT], cfg_in [LANE_COUNT];
    logic [LANE_COUNT-1:0][WORD_W-1:0] lane_datapath;
    logic [WORD_W-1:0] exp_word [2];
    integer seed = 32'hdb22;
    int failures = 0, comparisons = 0, cycles = 0;

    llcr_top #(.LANES(LANE_COUNT)) DUT (.*);
    llcr_far_model far (.*);

    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end

    // ****************************************
    // capture tracking and hang guard
    // ****************************************
    always @(posedge aclk) begin
        cycles++;
        if (aresetn && datapath_capture_strobe) begin
            exp_word[0] = lane_datapath[sel[0]];
            exp_word[1] = lane_datapath[2 + sel[1]];
        end
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    function automatic logic [7:0] cfg_byte(llcr_lane_cfg_type c, int b);
        case (b)
            0: return c.rx_link_ident;
            1: return {c.rx_adjust_count, c.rx_bank_ident};
            2: return {1'h0, c.rx_adjust_direction,
                c.rx_phase_adjust_req, c.rx_lane_ident};
            3: return {c.rx_scramble_on, 2'h0, c.rx_lane_count_m1};
            4: return c.rx_octets_per_frame_m1;
            5: return {3'h0, c.rx_frames_per_multi_m1};
            6: return c.rx_converters_m1;
            7: return {c.rx_control_bit_count, 1'h0,
                c.rx_resolution_m1};
            8: return {c.rx_subclass_code,
                c.rx_bits_per_sample_m1};
            9: return {c.rx_standard_version,
                c.rx_samples_per_frame_m1};
            10: return {c.rx_high_density, 2'h0,
                c.rx_ctrl_words_per_frame};
            11: return c.rx_spare_octet_one;
            12: return c.rx_spare_octet_two;
            default: return c.rx_config_checksum;
        endcase
    endfunction

    task check_data(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task check_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // ****************************************
    // bus master
    // ****************************************
    task bus_write(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                   input logic [3:0] s);
        bit a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        awaddr <= {idx, 2'h0};
        wdata <= {24'($random(seed)), d};
        wstrb <= s;
        while (!(a && w)) begin
            @(posedge aclk);
            if (awvalid === 1'h1 && awready === 1'h1) begin
                a = 1'b1;
                awvalid <= 1'h0;
            end
            if (wvalid === 1'h1 && wready === 1'h1) begin
                w = 1'b1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task rd_check(input logic [IDX_W-1:0] idx, input logic [7:0] e,
                  input logic [1:0] er, input string n);
        @(posedge aclk);
        arvalid <= 1'h1;
        araddr <= {idx, 2'h0};
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        check_data(n, {24'h0, e}, rdata);
        check_resp(n, er, rresp);
    endtask

    task pulse();
        @(posedge aclk);
        strobe_req <= 1'h1;
        @(posedge aclk);
        strobe_req <= 1'h0;
        // lane words keep moving while the captured word must hold
        repeat (20) @(posedge aclk);
    endtask

    task rd_pair(input int p);
        rd_check(PAIR_LOW_IDX[p], exp_word[p][7:0], RESP_OKAY, "word low");
        rd_check(PAIR_HIGH_IDX[p], exp_word[p][15:8], RESP_OKAY, "word high");
    endtask

    task reset_capture();
        aresetn <= 1'h0;
        sel = 2'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        pulse();
        rd_pair(1);
    endtask

    task final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, strobe_req} = '0;
        {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
        load_req = 4'h0;
        cfg_next = '{default: '0};
        reset_capture();
        rd_check(PAIR_CHOICE_IDX[1], 8'h00, RESP_OKAY, "choice");
        for (int r = 0; r < 3; r++) begin
            @(posedge aclk);
            for (int l = 0; l < LANE_COUNT; l++) begin
                raw = {$random(seed), $random(seed), $random(seed),
                       $random(seed)};
                rnd_cfg = llcr_lane_cfg_type'(raw[$bits(rnd_cfg)-1:0]);
                rnd_cfg.rx_subclass_code = 3'(r);
                rnd_cfg.rx_standard_version = 3'(r % 2);
                cfg_next[l] <= rnd_cfg;
            end
            load_req <= 4'hf;
            @(posedge aclk);
            load_req <= 4'h0;
            for (int l = 0; l < LANE_COUNT; l++)
                for (int b = 0; b < 14; b++)
                    rd_check(IDX_W'(LANE_BASE_IDX + l * LANE_STRIDE + b),
                        cfg_byte(cfg_next[l], b), RESP_OKAY, "cfg");
        end
        for (int k = 0; k < 4; k++) begin
            bus_write(PAIR_CHOICE_IDX[k / 2], 8'(k % 2), 4'hf);
            check_resp("choice write", RESP_OKAY, resp);
            sel[k / 2] = 1'(k % 2);
            pulse();
            rd_pair(k / 2);
        end
        bus_write(PAIR_CHOICE_IDX[0], 8'h00, 4'h0);
        check_resp("masked write", RESP_OKAY, resp);
        pulse();
        rd_pair(0);
        bus_write(LANE_BASE_IDX, 8'h5a, 4'hf);
        check_resp("cfg write", RESP_SLVERR, resp);
        rd_check(LANE_BASE_IDX, cfg_byte(cfg_next[0], 0), RESP_OKAY,
            "cfg kept");
        rd_check(10'h3ff, 8'h00, RESP_SLVERR, "unmapped");
        @(posedge aclk);
        reset_capture();
        final_report();
    end
endmodule
`default_nettype wire
